/* File: flash_sequencer.sv */
// Fault lamp sequencer: first digit flashes, pause, second digit, pause.
// Assumes digits are stable while active and tick is a 1 ms pulse.
`timescale 1ns/100ps
module flash_sequencer #(
  parameter int ON_MS = lift_pressure_pkg::FLASH_ON_MS,
  parameter int OFF_MS = lift_pressure_pkg::FLASH_OFF_MS,
  parameter int PAUSE_MS = lift_pressure_pkg::FLASH_PAUSE_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Timebase
  input wire logic tick,
  // Code to show
  input wire logic active,
  input wire logic [3:0] first_digit,
  input wire logic [3:0] second_digit,
  // Lamp
  output logic lamp
);

  localparam int TW = lift_pressure_pkg::TIMER_W;

  typedef struct packed {
    lift_pressure_pkg::flash_state_t state;
    logic [3:0] digit2;
    logic [3:0] left;
    logic second;
    logic [TW-1:0] time_ms;
    logic lamp;
  } flash_reg_t;

  flash_reg_t st;
  flash_reg_t next_st;

  // Phase end on this tick
  function automatic logic phase_done(input logic [TW-1:0] t, input int lim);
    phase_done = (t + 1'b1) >= TW'(lim);
  endfunction

  always_comb begin
    next_st = st;
    if (!active) begin
      next_st.state = lift_pressure_pkg::FL_IDLE;
      next_st.lamp = 1'b0;
      next_st.time_ms = '0;
    end else begin
      case (st.state)
        lift_pressure_pkg::FL_IDLE: begin
          next_st.digit2 = second_digit;
          next_st.left = first_digit;
          next_st.second = 1'b0;
          next_st.time_ms = '0;
          if (first_digit != 4'h0) begin
            next_st.state = lift_pressure_pkg::FL_ON;
            next_st.lamp = 1'b1;
          end else begin
            next_st.state = lift_pressure_pkg::FL_PAUSE;
          end
        end
        lift_pressure_pkg::FL_ON: begin
          if (tick) begin
            next_st.time_ms = st.time_ms + 1'b1;
            if (phase_done(st.time_ms, ON_MS)) begin
              next_st.time_ms = '0;
              next_st.lamp = 1'b0;
              next_st.left = st.left - 1'b1;
              if (st.left == 4'h1) begin
                next_st.state = lift_pressure_pkg::FL_PAUSE;
              end else begin
                next_st.state = lift_pressure_pkg::FL_OFF;
              end
            end
          end
        end
        lift_pressure_pkg::FL_OFF: begin
          if (tick) begin
            next_st.time_ms = st.time_ms + 1'b1;
            if (phase_done(st.time_ms, OFF_MS)) begin
              next_st.time_ms = '0;
              next_st.lamp = 1'b1;
              next_st.state = lift_pressure_pkg::FL_ON;
            end
          end
        end
        lift_pressure_pkg::FL_PAUSE: begin
          if (tick) begin
            next_st.time_ms = st.time_ms + 1'b1;
            if (phase_done(st.time_ms, PAUSE_MS)) begin
              next_st.time_ms = '0;
              if (!st.second && st.digit2 != 4'h0) begin
                next_st.second = 1'b1;
                next_st.left = st.digit2;
                next_st.lamp = 1'b1;
                next_st.state = lift_pressure_pkg::FL_ON;
              end else begin
                next_st.state = lift_pressure_pkg::FL_IDLE;
              end
            end
          end
        end
        default: begin
          next_st.state = lift_pressure_pkg::FL_IDLE;
          next_st.lamp = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '{state: lift_pressure_pkg::FL_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign lamp = st.lamp;

endmodule

/* File: lift_pressure_fault_monitor.sv */
// Lift cylinder pressure transducer supervisor with flash-code lamp.
// Assumes converted analog samples on ref_clk (uA, mV, PSI) and motion
// status levels arriving from outside the clock domain.
//
// Notes on behaviour
// - Primary head current under 3.5 mA for 500 ms raises the primary low fault.
// - Primary head voltage under 0.25 V for 500 ms also raises the primary low fault.
// - Backup head current over 22.0 mA or voltage over 4.75 V for 500 ms raises backup high.
// - Backup head current under 3.5 mA or voltage under 0.25 V for 500 ms raises backup low.
// - Primary and backup head pressures differing by over 75 PSI for 500 ms is a fault.
// - Rod voltage above 4.75 V for 500 ms raises the rod high fault.
// - Rod voltage below 0.25 V for 500 ms raises the rod low fault.
// - Rod pressure not under 50 PSI within 3000 ms raises the rod decay fault.
// - The decay check only runs while driving, lifting and steering are all off.
// - The lamp flashes the first code digit, pauses, flashes the second, pauses.
// - The lamp sequence repeats while a fault is active and stops once it clears.
// - The full trouble code goes only to the diagnostic port; the lamp shows two digits.
// - Primary head current above 22.0 mA for 500 ms raises the primary high fault.
`timescale 1ns/100ps
module lift_pressure_fault_monitor #(
  parameter int CYCLES_PER_MS = lift_pressure_pkg::CYCLES_PER_MS,
  parameter int PERSIST_MS = lift_pressure_pkg::PERSIST_MS,
  parameter int DECAY_MS = lift_pressure_pkg::DECAY_MS,
  parameter int FLASH_ON_MS = lift_pressure_pkg::FLASH_ON_MS,
  parameter int FLASH_OFF_MS = lift_pressure_pkg::FLASH_OFF_MS,
  parameter int FLASH_PAUSE_MS = lift_pressure_pkg::FLASH_PAUSE_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Head pressure channels
  input wire logic [15:0] primary_head_current_in,
  input wire logic [15:0] primary_head_voltage_in,
  input wire logic [15:0] backup_head_current_in,
  input wire logic [15:0] backup_head_voltage_in,
  input wire logic [15:0] primary_head_psi,
  input wire logic [15:0] backup_head_psi,
  // Rod pressure channel
  input wire logic [15:0] rod_pressure_voltage_in,
  input wire logic [15:0] rod_psi,
  // Machine motion status, asynchronous
  input wire logic driving,
  input wire logic lifting,
  input wire logic steering,
  // Indicator and diagnostic tool
  output logic system_fault_lamp,
  output logic [15:0] diag_code,
  output logic diag_valid,
  output logic [7:0] fault_active
);

  localparam int NF = lift_pressure_pkg::NUM_FAULTS;
  localparam int MW = lift_pressure_pkg::MS_CNT_W;
  localparam logic [MW-1:0] MS_LAST = MW'(CYCLES_PER_MS - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic below(input logic [15:0] v, input logic [15:0] lim);
    below = v < lim;
  endfunction

  function automatic logic above(input logic [15:0] v, input logic [15:0] lim);
    above = v > lim;
  endfunction

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction

  // Three-stage synchroniser step with agreement filter
  function automatic logic [3:0] sync_step(input logic [3:0] s, input logic pin);
    logic [3:0] r;
    r = {s[3], s[1], s[0], pin};
    if (s[1] == s[2]) begin
      r[3] = s[2];
    end
    sync_step = r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] drive_sync;
    logic [3:0] lift_sync;
    logic [3:0] steer_sync;
    logic [MW-1:0] ms_cnt;
    logic tick;
    logic [NF-1:0] fault;
    logic [15:0] code;
    logic code_valid;
  } monitor_state_t;

  monitor_state_t st;
  monitor_state_t next_st;
  logic [NF-1:0] cond;
  logic [NF-1:0] hit;
  logic machine_idle;
  logic [15:0] pick_code;
  logic lamp;

  // ----------------------------------------------------------------
  // Fault conditions
  // ----------------------------------------------------------------
  assign machine_idle = !st.drive_sync[3] && !st.lift_sync[3] && !st.steer_sync[3];

  always_comb begin
    cond = '0;
    cond[lift_pressure_pkg::F_PRI_HIGH] =
      above(primary_head_current_in, lift_pressure_pkg::CURRENT_HIGH_UA)
      || above(primary_head_voltage_in, lift_pressure_pkg::VOLT_HIGH_MV);
    cond[lift_pressure_pkg::F_PRI_LOW] =
      below(primary_head_current_in, lift_pressure_pkg::CURRENT_LOW_UA)
      || below(primary_head_voltage_in, lift_pressure_pkg::VOLT_LOW_MV);
    cond[lift_pressure_pkg::F_BAK_HIGH] =
      above(backup_head_current_in, lift_pressure_pkg::CURRENT_HIGH_UA)
      || above(backup_head_voltage_in, lift_pressure_pkg::VOLT_HIGH_MV);
    cond[lift_pressure_pkg::F_BAK_LOW] =
      below(backup_head_current_in, lift_pressure_pkg::CURRENT_LOW_UA)
      || below(backup_head_voltage_in, lift_pressure_pkg::VOLT_LOW_MV);
    cond[lift_pressure_pkg::F_DISAGREE] =
      above(abs_diff(primary_head_psi, backup_head_psi),
            lift_pressure_pkg::DISAGREE_PSI);
    cond[lift_pressure_pkg::F_ROD_HIGH] =
      above(rod_pressure_voltage_in, lift_pressure_pkg::VOLT_HIGH_MV);
    cond[lift_pressure_pkg::F_ROD_LOW] =
      below(rod_pressure_voltage_in, lift_pressure_pkg::VOLT_LOW_MV);
    cond[lift_pressure_pkg::F_ROD_DECAY] = machine_idle
      && !below(rod_psi, lift_pressure_pkg::DECAY_PSI);
  end

  // ----------------------------------------------------------------
  // Persistence timers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NF; i++) begin : g_persist
    persist_timer #(
      .LIMIT((i == lift_pressure_pkg::F_ROD_DECAY) ? DECAY_MS : PERSIST_MS)
    ) u_persist (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(st.tick),
      .cond(cond[i]),
      .hit(hit[i])
    );
  end

  // ----------------------------------------------------------------
  // Code selection: highest active code
  // ----------------------------------------------------------------
  always_comb begin
    pick_code = lift_pressure_pkg::CODE_NONE;
    for (int i = 0; i < NF; i++) begin
      if (st.fault[i]) begin
        pick_code = lift_pressure_pkg::FAULT_CODE[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.drive_sync = sync_step(st.drive_sync, driving);
    next_st.lift_sync = sync_step(st.lift_sync, lifting);
    next_st.steer_sync = sync_step(st.steer_sync, steering);
    next_st.tick = 1'b0;
    if (st.ms_cnt == MS_LAST) begin
      next_st.ms_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.ms_cnt = st.ms_cnt + 1'b1;
    end
    next_st.fault = hit;
    next_st.code = pick_code;
    next_st.code_valid = |st.fault;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Lamp: leading two digits only
  // ----------------------------------------------------------------
  flash_sequencer #(
    .ON_MS(FLASH_ON_MS),
    .OFF_MS(FLASH_OFF_MS),
    .PAUSE_MS(FLASH_PAUSE_MS)
  ) u_flash (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(st.tick),
    .active(st.code_valid),
    .first_digit(st.code[15:12]),
    .second_digit(st.code[11:8]),
    .lamp(lamp)
  );

  assign system_fault_lamp = lamp;
  assign diag_code = st.code;
  assign diag_valid = st.code_valid;
  assign fault_active = st.fault;

endmodule

/* File: lift_pressure_fault_monitor_asserts.sv */
// Concurrent checks on the lift pressure fault monitor ports.
// Assumes one clock, ref_clk, and synchronous active-high rst.
`timescale 1ns/100ps
module lift_pressure_fault_monitor_asserts #(
  parameter int CYCLES_PER_MS = 10000,
  parameter int PERSIST_MS = 500
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched inputs
  input wire logic [15:0] primary_head_current_in,
  input wire logic [15:0] primary_head_voltage_in,
  input wire logic [15:0] rod_pressure_voltage_in,
  input wire logic driving,
  input wire logic lifting,
  input wire logic steering,
  // Watched outputs
  input wire logic system_fault_lamp,
  input wire logic [15:0] diag_code,
  input wire logic diag_valid,
  input wire logic [7:0] fault_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  localparam int MIN_RUN = PERSIST_MS * CYCLES_PER_MS;
  localparam int LIM = (PERSIST_MS + 1) * CYCLES_PER_MS + 2;
  logic pri_low;
  logic rod_low;
  logic moving;
  int run;
  assign pri_low = primary_head_current_in < 16'h0DAC || primary_head_voltage_in < 16'h00FA;
  assign rod_low = rod_pressure_voltage_in < 16'h00FA;
  assign moving = driving || lifting || steering;
  // Cycles the primary low condition has held unbroken
  always_ff @(posedge ref_clk) begin
    if (rst || !pri_low) begin
      run <= 0;
    end else begin
      run <= run + 1;
    end
  end
  a_low_too_soon: assert property ($rose(fault_active[1]) |-> run >= MIN_RUN)
    else $error("primary low fault rose too early");
  a_low_deadline: assert property (pri_low && run == LIM |-> fault_active[1])
    else $error("primary low fault missing after persistence time");
  a_rod_clears: assert property (!rod_low [*3] |=> !fault_active[6])
    else $error("rod low fault stayed after condition cleared");
  a_motion_blocks: assert property (moving [*8] |=> !$rose(fault_active[7]))
    else $error("decay fault rose while machine moving");
  a_valid_follows: assert property (diag_valid == ($past(fault_active) != 8'h00))
    else $error("diag_valid does not follow fault_active");
  a_code_decay: assert property ($past(fault_active[7]) |-> diag_code == 16'h8532)
    else $error("decay code not shown");
  a_code_idle: assert property (!diag_valid |-> diag_code == 16'h0000)
    else $error("code shown with no fault");
  a_lamp_needs_fault: assert property (system_fault_lamp |-> $past(diag_valid))
    else $error("lamp lit without an active fault");
  a_lamp_on_hold: assert property ($rose(system_fault_lamp) ##0 diag_valid [*5]
    |-> system_fault_lamp)
    else $error("lamp flash too short");
  c_decay: cover property ($rose(fault_active[7]));
  c_lamp: cover property ($rose(system_fault_lamp));
  c_clear: cover property ($fell(diag_valid));
endmodule

bind lift_pressure_fault_monitor lift_pressure_fault_monitor_asserts #(
  .CYCLES_PER_MS(CYCLES_PER_MS),
  .PERSIST_MS(PERSIST_MS)
) u_chk (
  .ref_clk(ref_clk),
  .rst(rst),
  .primary_head_current_in(primary_head_current_in),
  .primary_head_voltage_in(primary_head_voltage_in),
  .rod_pressure_voltage_in(rod_pressure_voltage_in),
  .driving(driving),
  .lifting(lifting),
  .steering(steering),
  .system_fault_lamp(system_fault_lamp),
  .diag_code(diag_code),
  .diag_valid(diag_valid),
  .fault_active(fault_active)
);

/* File: lift_pressure_fault_monitor_tb_top.sv */
// Self-checking bench: forced transducer faults, motion, lamp codes.
// Assumes shortened ms timebase and flash times set at the instance.
`timescale 1ns/100ps
module lift_pressure_fault_monitor_tb_top;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
  logic ref_clk = 1'b0;
  logic rst, system_fault_lamp, diag_valid;
  logic [3:0] sel;
  logic [7:0] fault_active;
  logic [7:0] noise = 8'h00;
  logic [2:0] motion;
  logic [15:0] pri_ua, pri_mv, bak_ua, bak_mv, pri_psi, bak_psi, rod_mv, rod_psi;
  logic [15:0] diag_code;
  // Xorshift start value 23158
  logic [15:0] seed = 16'h5A76;
  // Shortened timebase and flash times for the bench
  localparam int MS_CYC = 4;
  localparam int PERSIST = 5;
  localparam int DECAY = 8;
  localparam int ON_TIME = 2;
  localparam int OFF_TIME = 2;
  localparam int PAUSE_TIME = 5;
  logic [7:0] q[$];
  int err_count, tests_run, cycles;
  logic [7:0] exp_mask [14] = '{8'h00, 8'h02, 8'h02, 8'h01, 8'h04, 8'h04, 8'h08, 8'h08,
    8'h10, 8'h20, 8'h40, 8'h80, 8'h00, 8'h00};
  pressure_transducers xdcr (.sel(sel), .noise(noise), .pri_ua(pri_ua), .pri_mv(pri_mv),
    .bak_ua(bak_ua), .bak_mv(bak_mv), .pri_psi(pri_psi), .bak_psi(bak_psi),
    .rod_mv(rod_mv), .rod_psi(rod_psi));
  lift_pressure_fault_monitor #(.CYCLES_PER_MS(MS_CYC), .PERSIST_MS(PERSIST),
    .DECAY_MS(DECAY), .FLASH_ON_MS(ON_TIME), .FLASH_OFF_MS(OFF_TIME),
    .FLASH_PAUSE_MS(PAUSE_TIME)) uut (
    .ref_clk(ref_clk), .rst(rst), .primary_head_current_in(pri_ua),
    .primary_head_voltage_in(pri_mv), .backup_head_current_in(bak_ua),
    .backup_head_voltage_in(bak_mv), .primary_head_psi(pri_psi),
    .backup_head_psi(bak_psi), .rod_pressure_voltage_in(rod_mv), .rod_psi(rod_psi),
    .driving(motion[0]), .lifting(motion[1]), .steering(motion[2]),
    .system_fault_lamp(system_fault_lamp), .diag_code(diag_code),
    .diag_valid(diag_valid), .fault_active(fault_active));
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction
  function automatic logic [15:0] code_of(input logic [7:0] m);
    logic [15:0] c;
    c = 16'h0000;
    for (int b = 0; b < 8; b++) begin
      if (m[b]) c = (b == 7) ? 16'h8532 : 16'h8523 + 16'(b);
    end
    return c;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (q.size() != 0 && k < 60) begin
      @(negedge ref_clk);
      k++;
    end
    `CHK("drain", 0, q.size())
    @(negedge ref_clk);
  endtask
  task automatic flash_group(input int n);
    int cnt, low;
    logic prev;
    cnt = 0;
    low = 0;
    prev = 1'b0;
    while ((cnt == 0 && low < 200) || (cnt > 0 && low < 16)) begin
      @(negedge ref_clk);
      if (system_fault_lamp === 1'b1 && prev !== 1'b1) cnt++;
      low = (system_fault_lamp === 1'b1) ? 0 : low + 1;
      prev = system_fault_lamp;
    end
    `CHK("flashes", n, cnt)
  endtask
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    seed <= xs(seed);
    noise <= seed[7:0];
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  // Watches fault changes and checks each against the oldest note
  initial begin
    logic [7:0] prev, n;
    prev = 8'h00;
    forever begin
      @(negedge ref_clk);
      if (rst === 1'b0 && fault_active !== prev) begin
        prev = fault_active;
        n = (q.size() != 0) ? q.pop_front() : 8'hFF;
        `CHK("fault_active", n, prev)
        @(negedge ref_clk);
        `CHK("diag_code", code_of(n), diag_code)
        `CHK("diag_valid", n != 8'h00, diag_valid)
      end
    end
  end
  initial begin
    rst = 1'b1;
    sel = 4'h0;
    motion = 3'b000;
    repeat (2) @(negedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(negedge ref_clk);
    for (int i = 1; i < 14; i++) begin
      sel <= i[3:0];
      if (i == 1) begin
        repeat (16) @(negedge ref_clk);
        sel <= 4'h0;
        repeat (2) @(negedge ref_clk);
        sel <= 4'h1;
        repeat (15) @(negedge ref_clk);
        `CHK("restart", 8'h00, fault_active)
      end
      if (exp_mask[i] == 8'h00) begin
        repeat (60) @(negedge ref_clk);
        `CHK("boundary", 8'h00, fault_active)
      end else begin
        q.push_back(exp_mask[i]);
        drain();
        if (i == 11) begin
          flash_group(8);
          flash_group(5);
          flash_group(8);
          for (int m = 0; m < 3; m++) begin
            q.push_back(8'h00);
            motion[m] <= 1'b1;
            drain();
            repeat (60) @(negedge ref_clk);
            q.push_back(8'h80);
            motion[m] <= 1'b0;
            drain();
          end
        end
        q.push_back(8'h00);
        sel <= 4'h0;
        drain();
        repeat (2) @(negedge ref_clk);
        `CHK("lamp_off", 1'b0, system_fault_lamp)
      end
      $display("test %0d done", i);
    end
    end_of_test();
  end
endmodule

/* File: lift_pressure_pkg.sv */
// Constants and types shared by the lift pressure fault monitor.
// Assumes a 10 MHz system clock and digitised inputs in uA, mV and PSI.
package lift_pressure_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_CNT_W = 16;
  localparam int TIMER_W = 12;

  // ----------------------------------------------------------------
  // Persistence and indicator times, in ms
  // ----------------------------------------------------------------
  localparam int PERSIST_MS = 500;
  localparam int DECAY_MS = 3000;
  localparam int FLASH_ON_MS = 500;
  localparam int FLASH_OFF_MS = 500;
  localparam int FLASH_PAUSE_MS = 1500;

  // ----------------------------------------------------------------
  // Thresholds: currents in uA, voltages in mV, pressures in PSI
  // ----------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam logic [15:0] CURRENT_LOW_UA = 16'h0DAC;
  localparam logic [15:0] CURRENT_HIGH_UA = 16'h55F0;
  localparam logic [15:0] VOLT_LOW_MV = 16'h00FA;
  localparam logic [15:0] VOLT_HIGH_MV = 16'h128E;
  localparam logic [15:0] DISAGREE_PSI = 16'h004B;
  localparam logic [15:0] DECAY_PSI = 16'h0032;

  // ----------------------------------------------------------------
  // Fault slots and their trouble codes (BCD)
  // ----------------------------------------------------------------
  localparam int NUM_FAULTS = 8;
  localparam int F_PRI_HIGH = 0;
  localparam int F_PRI_LOW = 1;
  localparam int F_BAK_HIGH = 2;
  localparam int F_BAK_LOW = 3;
  localparam int F_DISAGREE = 4;
  localparam int F_ROD_HIGH = 5;
  localparam int F_ROD_LOW = 6;
  localparam int F_ROD_DECAY = 7;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] FAULT_CODE [NUM_FAULTS] = '{
    16'h8523, 16'h8524, 16'h8525, 16'h8526,
    16'h8527, 16'h8528, 16'h8529, 16'h8532
  };

  typedef enum {FL_IDLE, FL_ON, FL_OFF, FL_PAUSE} flash_state_t;

endpackage

/* File: persist_timer.sv */
// Persistence qualifier: hit rises once cond has held a full LIMIT ms.
// Assumes tick is a one-cycle pulse per millisecond on the same clock.
`timescale 1ns/100ps
module persist_timer #(
  parameter int LIMIT = lift_pressure_pkg::PERSIST_MS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Timebase and condition
  input wire logic tick,
  input wire logic cond,
  // Qualified result
  output logic hit
);

  typedef struct packed {
    logic [lift_pressure_pkg::TIMER_W-1:0] cnt;
    logic hit;
  } persist_state_t;

  // One tick beyond the limit, so the first partial ms never counts
  localparam logic [lift_pressure_pkg::TIMER_W-1:0] LIM =
    lift_pressure_pkg::TIMER_W'(LIMIT + 1);

  persist_state_t st;
  persist_state_t next_st;

  always_comb begin
    next_st = st;
    if (!cond) begin
      next_st.cnt = '0;
      next_st.hit = 1'b0;
    end else if (tick && st.cnt != LIM) begin
      next_st.cnt = st.cnt + 1'b1;
    end
    if (cond && next_st.cnt == LIM) begin
      next_st.hit = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hit = st.hit;

endmodule

/* File: pressure_transducers.sv */
// Converted transducer readings: healthy with noise, or one forced case.
// Assumes sel and noise change at the falling clock edge.
`timescale 1ns/100ps
module pressure_transducers (
  // Control
  input wire logic [3:0] sel,
  input wire logic [7:0] noise,
  // Readings in uA, mV and PSI
  output logic [15:0] pri_ua,
  output logic [15:0] pri_mv,
  output logic [15:0] bak_ua,
  output logic [15:0] bak_mv,
  output logic [15:0] pri_psi,
  output logic [15:0] bak_psi,
  output logic [15:0] rod_mv,
  output logic [15:0] rod_psi
);
  always_comb begin
    pri_ua = 16'h2EE0 + noise;
    pri_mv = 16'h09C4 + noise;
    bak_ua = 16'h2EE0 + noise;
    bak_mv = 16'h09C4 + noise;
    pri_psi = 16'h03E8 + noise;
    bak_psi = 16'h03E8 + noise;
    rod_mv = 16'h09C4 + noise;
    rod_psi = 16'h0014 + noise[3:0];
    case (sel)
      4'h1: pri_ua = 16'h0064;
      4'h2: pri_mv = 16'h0064;
      4'h3: pri_ua = 16'h59D8;
      4'h4: bak_ua = 16'h59D8;
      4'h5: bak_mv = 16'h1388;
      4'h6: bak_ua = 16'h0064;
      4'h7: bak_mv = 16'h0064;
      4'h8: bak_psi = pri_psi + 16'h004C;
      4'h9: rod_mv = 16'h1388;
      4'hA: rod_mv = 16'h0064;
      4'hB: rod_psi = 16'h0032;
      4'hC: begin
        pri_ua = 16'h0DAC;
        pri_mv = 16'h00FA;
        bak_ua = 16'h55F0;
        bak_mv = 16'h128E;
        bak_psi = pri_psi + 16'h004B;
        rod_mv = 16'h00FA;
        rod_psi = 16'h0031;
      end
      4'hD: begin
        pri_ua = 16'h55F0;
        pri_mv = 16'h128E;
        bak_ua = 16'h0DAC;
        bak_mv = 16'h00FA;
        bak_psi = pri_psi - 16'h004B;
        rod_mv = 16'h128E;
      end
      default: ;
    endcase
  end
endmodule
